// >>> hdl/rws_pkg.sv
// Purpose: shared constants and types of the reset and wake sequencer
// Assumes: one 25 MHz clock; oscillator and pins arrive asynchronously
// Notes: counts are in cycles of the clock they name
package rws_pkg;

    // clock rate of clk, for reference by the bench
    localparam int RWS_CLK_HZ = 25000000;

    // watchdog-oscillator phase lengths (514 and 66 cycles)
    localparam logic [9:0] RWS_OSC_LONG = 10'h202;
    localparam logic [9:0] RWS_OSC_SHORT = 10'h042;
    localparam logic [9:0] RWS_OSC_ZERO = 10'h000;

    // system-clock phase length (16 cycles)
    localparam logic [4:0] RWS_SYS_COUNT = 5'h10;
    localparam logic [4:0] RWS_SYS_ZERO = 5'h00;

    // reset vector address handed to the core
    localparam logic [15:0] RWS_VECTOR_ADDR = 16'h0002;

    // gpio wake inputs
    localparam int RWS_GPIO_W = 8;

    // positions inside the synchronised input vector
    localparam int RWS_SYNC_W = 13;
    localparam int RWS_SI_SUPPLY = 0;
    localparam int RWS_SI_BROWN = 1;
    localparam int RWS_SI_OSC = 2;
    localparam int RWS_SI_PIN = 3;
    localparam int RWS_SI_DBG = 4;
    localparam int RWS_SI_GPIO = 5;
    // reset value: supply bad, pins idle high, gpio low
    localparam logic [12:0] RWS_SYNC_RST = 13'h0018;

    // positions inside the 4-bit cause vector
    localparam int RWS_CAUSE_W = 4;
    localparam int RWS_CA_POR = 0;
    localparam int RWS_CA_WDT = 1;
    localparam int RWS_CA_EXT = 2;
    localparam int RWS_CA_WAKE = 3;
    localparam logic [3:0] RWS_CAUSE_NONE = 4'h0;
    localparam logic [3:0] RWS_CAUSE_POR = 4'h1;
    localparam logic [3:0] RWS_CAUSE_WDT = 4'h2;
    localparam logic [3:0] RWS_CAUSE_EXT = 4'h4;
    localparam logic [3:0] RWS_CAUSE_WAKE = 4'h8;
    localparam logic [3:0] RWS_CAUSE_WDT_WAKE = 4'ha;

    typedef enum logic [2:0] {
        RWS_ST_RUN = 3'h0,
        RWS_ST_HOLD = 3'h1,
        RWS_ST_OSC = 3'h2,
        RWS_ST_SYS = 3'h3,
        RWS_ST_PIN = 3'h4
    } rws_state_t;

    typedef enum logic [1:0] {
        RWS_KIND_LONG = 2'h0,
        RWS_KIND_SHORT = 2'h1,
        RWS_KIND_WAKE = 2'h2
    } rws_kind_t;

endpackage

// >>> hdl/rws_sync.sv
// Purpose: three-flop input synchroniser with agreement filter
// Assumes: inputs are asynchronous to clk
// Notes: an output bit changes only once stages two and three agree
`timescale 1ns/1ps
module rws_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] out_reg;
    logic [W-1:0] out_next;

    // stage one feeds stage two only, never the filter
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i]
                                                       : out_reg[i];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            out_reg <= RST_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign sync_out = out_reg;
endmodule

// >>> hdl/rws_sequencer.sv
// Purpose: collects reset and wake requests and sequences the chip out
// Assumes: clk is the system clock; the watchdog oscillator is a pin
// Notes: sleep state and watchdog time-out come from on-chip logic
`timescale 1ns/1ps

// How it works
// - in sleep, watchdog time-out or enabled gpio change wake it
// - long reset holds 514 oscillator cycles then 16 system clocks
// - short reset is the same but only 66 oscillator cycles
// - wake recovery is 514 plus 16; resets core and peripherals only, not debugger or registers
// - core idle during reset; system clock runs only after oscillator count
// - long or short reset loads defined control register reset values
// - after any sequence core fetches vector from 0002H and 0003H
// - awake: supply loss long, watchdog or pin short, debugger long
// - in sleep, supply loss, pin or debug low give a long reset
// - supply loss and brown-out outrank every other reset source
// - after supply good count oscillator then system clocks, then release
// - power-up or brown-out completion sets the power-up cause flag
// - brown-out holds reset while low, then runs the full long sequence
// - brown-out detector is disabled in sleep
// - awake watchdog time-out resets only when the select option is 1
// - a watchdog-caused reset sets the watchdog cause flag
// - reset pin starts short reset and holds it until the pin is released
// - pin-caused short reset sets the external pin cause flag
// - any wake recovery sets the sleep-wake cause flag
// - watchdog wake sets both flags; its interrupt is raised afterwards
// - either edge on an enabled gpio wake input starts wake recovery
// - port inputs disabled in sleep; capture only at recovery end
module rws_sequencer (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_good,
    input wire logic brownout_detect,
    input wire logic wdt_osc,
    input wire logic reset_pin_n,
    input wire logic debug_pin,
    input wire logic [rws_pkg::RWS_GPIO_W-1:0] gpio_wake_in,
    input wire logic [rws_pkg::RWS_GPIO_W-1:0] gpio_wake_en,
    input wire logic sleep_mode,
    input wire logic wdt_timeout,
    input wire logic watchdog_reset_select_option,
    input wire logic wdt_irq_mode,
    input wire logic debugger_control_reg_bit1,
    input wire logic flag_clear,
    output logic core_reset,
    output logic periph_reset,
    output logic debugger_reset,
    output logic ctrl_reg_load,
    output logic sys_clk_run,
    output logic brownout_enable,
    output logic port_input_enable,
    output logic port_input_capture,
    output logic vector_fetch,
    output logic [15:0] vector_addr,
    output logic wdt_irq_request,
    output logic por_cause_flag,
    output logic watchdog_cause_flag,
    output logic external_pin_cause_flag,
    output logic sleep_wake_cause_flag
);
    logic [rws_pkg::RWS_SYNC_W-1:0] raw_in;
    logic [rws_pkg::RWS_SYNC_W-1:0] syn_in;
    logic supply_s;
    logic brown_s;
    logic osc_s;
    logic pin_n_s;
    logic dbg_s;
    logic [rws_pkg::RWS_GPIO_W-1:0] gpio_s;

    rws_pkg::rws_state_t state_reg;
    rws_pkg::rws_state_t state_next;
    rws_pkg::rws_kind_t kind_reg;
    rws_pkg::rws_kind_t kind_next;
    logic [9:0] osc_cnt_reg;
    logic [9:0] osc_cnt_next;
    logic [4:0] sys_cnt_reg;
    logic [4:0] sys_cnt_next;
    logic [3:0] cause_reg;
    logic [3:0] cause_next;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic spare_dbg_reg;
    logic spare_dbg_next;
    logic osc_prev_reg;
    logic [rws_pkg::RWS_GPIO_W-1:0] gpio_prev_reg;
    logic core_reset_reg;
    logic core_reset_next;
    logic dbg_reset_reg;
    logic dbg_reset_next;
    logic load_reg;
    logic load_next;
    logic sys_run_reg;
    logic sys_run_next;
    logic fetch_reg;
    logic fetch_next;
    logic capture_reg;
    logic capture_next;
    logic irq_reg;
    logic irq_next;

    logic osc_tick;
    logic supply_loss;
    logic gpio_change;
    logic done;

    assign raw_in = {gpio_wake_in, debug_pin, reset_pin_n, wdt_osc,
                     brownout_detect, supply_good};

    rws_sync #(
        .W(rws_pkg::RWS_SYNC_W),
        .RST_VAL(rws_pkg::RWS_SYNC_RST)
    ) u_sync (
        .clk(clk),
        .nrst(nrst),
        .async_in(raw_in),
        .sync_out(syn_in)
    );

    assign supply_s = syn_in[rws_pkg::RWS_SI_SUPPLY];
    assign brown_s = syn_in[rws_pkg::RWS_SI_BROWN];
    assign osc_s = syn_in[rws_pkg::RWS_SI_OSC];
    assign pin_n_s = syn_in[rws_pkg::RWS_SI_PIN];
    assign dbg_s = syn_in[rws_pkg::RWS_SI_DBG];
    assign gpio_s = syn_in[rws_pkg::RWS_SI_GPIO +: rws_pkg::RWS_GPIO_W];

    // one tick per rising edge of the watchdog oscillator
    assign osc_tick = osc_s & ~osc_prev_reg;

    // brown-out is ignored while asleep since the detector is off there
    assign supply_loss = ~supply_s | (brown_s & ~sleep_mode);

    assign gpio_change = |((gpio_s ^ gpio_prev_reg) & gpio_wake_en);

    // state machine and sequence bookkeeping
    always_comb begin
        state_next = state_reg;
        kind_next = kind_reg;
        osc_cnt_next = osc_cnt_reg;
        sys_cnt_next = sys_cnt_reg;
        cause_next = cause_reg;
        spare_dbg_next = spare_dbg_reg;
        done = 1'b0;
        case (state_reg)
            rws_pkg::RWS_ST_RUN: begin
                if (supply_loss) begin
                    state_next = rws_pkg::RWS_ST_HOLD;
                    kind_next = rws_pkg::RWS_KIND_LONG;
                    cause_next = rws_pkg::RWS_CAUSE_POR;
                    spare_dbg_next = 1'b0;
                end else if (sleep_mode) begin
                    if (!pin_n_s || !dbg_s) begin
                        state_next = rws_pkg::RWS_ST_OSC;
                        kind_next = rws_pkg::RWS_KIND_LONG;
                        cause_next = pin_n_s ? rws_pkg::RWS_CAUSE_NONE
                                             : rws_pkg::RWS_CAUSE_EXT;
                        spare_dbg_next = 1'b0;
                    end else if (wdt_timeout) begin
                        state_next = rws_pkg::RWS_ST_OSC;
                        kind_next = rws_pkg::RWS_KIND_WAKE;
                        cause_next = rws_pkg::RWS_CAUSE_WDT_WAKE;
                        spare_dbg_next = 1'b1;
                    end else if (gpio_change) begin
                        state_next = rws_pkg::RWS_ST_OSC;
                        kind_next = rws_pkg::RWS_KIND_WAKE;
                        cause_next = rws_pkg::RWS_CAUSE_WAKE;
                        spare_dbg_next = 1'b1;
                    end
                end else if (wdt_timeout && watchdog_reset_select_option) begin
                    state_next = rws_pkg::RWS_ST_OSC;
                    kind_next = rws_pkg::RWS_KIND_SHORT;
                    cause_next = rws_pkg::RWS_CAUSE_WDT;
                    spare_dbg_next = 1'b0;
                end else if (!pin_n_s) begin
                    state_next = rws_pkg::RWS_ST_OSC;
                    kind_next = rws_pkg::RWS_KIND_SHORT;
                    cause_next = rws_pkg::RWS_CAUSE_EXT;
                    spare_dbg_next = 1'b0;
                end else if (debugger_control_reg_bit1) begin
                    state_next = rws_pkg::RWS_ST_OSC;
                    kind_next = rws_pkg::RWS_KIND_LONG;
                    cause_next = rws_pkg::RWS_CAUSE_NONE;
                    spare_dbg_next = 1'b1;
                end
                osc_cnt_next = rws_pkg::RWS_OSC_ZERO;
                sys_cnt_next = rws_pkg::RWS_SYS_ZERO;
            end
            rws_pkg::RWS_ST_HOLD: begin
                // held for as long as the supply stays low
                osc_cnt_next = rws_pkg::RWS_OSC_ZERO;
                sys_cnt_next = rws_pkg::RWS_SYS_ZERO;
                if (!supply_loss) begin
                    state_next = rws_pkg::RWS_ST_OSC;
                end
            end
            rws_pkg::RWS_ST_OSC: begin
                if (osc_tick) begin
                    osc_cnt_next = osc_cnt_reg + 10'h001;
                end
                if ((kind_reg == rws_pkg::RWS_KIND_SHORT &&
                     osc_cnt_reg == rws_pkg::RWS_OSC_SHORT) ||
                    (kind_reg != rws_pkg::RWS_KIND_SHORT &&
                     osc_cnt_reg == rws_pkg::RWS_OSC_LONG)) begin
                    state_next = rws_pkg::RWS_ST_SYS;
                    osc_cnt_next = osc_cnt_reg;
                end
            end
            rws_pkg::RWS_ST_SYS: begin
                sys_cnt_next = sys_cnt_reg + 5'h01;
                if (sys_cnt_next == rws_pkg::RWS_SYS_COUNT) begin
                    state_next = pin_n_s ? rws_pkg::RWS_ST_RUN
                                         : rws_pkg::RWS_ST_PIN;
                    done = pin_n_s;
                end
            end
            rws_pkg::RWS_ST_PIN: begin
                // pin held past the count: leave as soon as it rises
                if (pin_n_s) begin
                    state_next = rws_pkg::RWS_ST_RUN;
                    done = 1'b1;
                end
            end
            default: begin
                state_next = rws_pkg::RWS_ST_HOLD;
            end
        endcase
        // a supply loss mid-sequence starts the long sequence over
        if (state_reg != rws_pkg::RWS_ST_RUN && supply_loss) begin
            state_next = rws_pkg::RWS_ST_HOLD;
            kind_next = rws_pkg::RWS_KIND_LONG;
            cause_next = rws_pkg::RWS_CAUSE_POR;
            spare_dbg_next = 1'b0;
            osc_cnt_next = rws_pkg::RWS_OSC_ZERO;
            sys_cnt_next = rws_pkg::RWS_SYS_ZERO;
            done = 1'b0;
        end
    end

    // cause flags and output strobes
    always_comb begin
        flags_next = flags_reg;
        if (flag_clear) begin
            flags_next = rws_pkg::RWS_CAUSE_NONE;
        end
        // a completing sequence writes after the clear, so the set wins
        if (done) begin
            if (kind_reg == rws_pkg::RWS_KIND_WAKE) begin
                flags_next = flags_next | cause_reg;
            end else begin
                flags_next = cause_reg;
            end
        end
        core_reset_next = (state_next != rws_pkg::RWS_ST_RUN);
        dbg_reset_next = core_reset_next & ~spare_dbg_next;
        // wake recovery leaves the register file alone
        load_next = core_reset_next &
                    (kind_next != rws_pkg::RWS_KIND_WAKE);
        sys_run_next = (state_next == rws_pkg::RWS_ST_RUN) ||
                       (state_next == rws_pkg::RWS_ST_SYS) ||
                       (state_next == rws_pkg::RWS_ST_PIN);
        fetch_next = done;
        capture_next = done & (kind_reg == rws_pkg::RWS_KIND_WAKE);
        irq_next = done & (kind_reg == rws_pkg::RWS_KIND_WAKE) &
                   cause_reg[rws_pkg::RWS_CA_WDT] & wdt_irq_mode;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_reg <= rws_pkg::RWS_ST_HOLD;
            kind_reg <= rws_pkg::RWS_KIND_LONG;
            osc_cnt_reg <= rws_pkg::RWS_OSC_ZERO;
            sys_cnt_reg <= rws_pkg::RWS_SYS_ZERO;
            cause_reg <= rws_pkg::RWS_CAUSE_POR;
            flags_reg <= rws_pkg::RWS_CAUSE_NONE;
            spare_dbg_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
            gpio_prev_reg <= '0;
            core_reset_reg <= 1'b1;
            dbg_reset_reg <= 1'b1;
            load_reg <= 1'b1;
            sys_run_reg <= 1'b0;
            fetch_reg <= 1'b0;
            capture_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            kind_reg <= kind_next;
            osc_cnt_reg <= osc_cnt_next;
            sys_cnt_reg <= sys_cnt_next;
            cause_reg <= cause_next;
            flags_reg <= flags_next;
            spare_dbg_reg <= spare_dbg_next;
            osc_prev_reg <= osc_s;
            gpio_prev_reg <= gpio_s;
            core_reset_reg <= core_reset_next;
            dbg_reset_reg <= dbg_reset_next;
            load_reg <= load_next;
            sys_run_reg <= sys_run_next;
            fetch_reg <= fetch_next;
            capture_reg <= capture_next;
            irq_reg <= irq_next;
        end
    end

    assign core_reset = core_reset_reg;
    assign periph_reset = core_reset_reg;
    assign debugger_reset = dbg_reset_reg;
    assign ctrl_reg_load = load_reg;
    assign sys_clk_run = sys_run_reg;
    assign brownout_enable = ~sleep_mode;
    // input data registers stay closed while asleep or recovering
    assign port_input_enable = ~sleep_mode & ~core_reset_reg;
    assign port_input_capture = capture_reg;
    assign vector_fetch = fetch_reg;
    assign vector_addr = rws_pkg::RWS_VECTOR_ADDR;
    assign wdt_irq_request = irq_reg;
    assign por_cause_flag = flags_reg[rws_pkg::RWS_CA_POR];
    assign watchdog_cause_flag = flags_reg[rws_pkg::RWS_CA_WDT];
    assign external_pin_cause_flag = flags_reg[rws_pkg::RWS_CA_EXT];
    assign sleep_wake_cause_flag = flags_reg[rws_pkg::RWS_CA_WAKE];
endmodule

// >>> testbench/rws_seq_properties.sv
// Purpose: port-level timing checks for the reset and wake sequencer
// Assumes: bound to rws_sequencer; one clock domain
// Notes: sys phase and pin-high age held in small saturating counters
`timescale 1ns/1ps
module rws_seq_properties (
    input wire logic clk,
    input wire logic nrst,
    input wire logic supply_good,
    input wire logic brownout_detect,
    input wire logic reset_pin_n,
    input wire logic sleep_mode,
    input wire logic wdt_timeout,
    input wire logic watchdog_reset_select_option,
    input wire logic core_reset,
    input wire logic periph_reset,
    input wire logic ctrl_reg_load,
    input wire logic sys_clk_run,
    input wire logic brownout_enable,
    input wire logic port_input_enable,
    input wire logic port_input_capture,
    input wire logic vector_fetch,
    input wire logic [15:0] vector_addr
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic [5:0] sys_reg;
    logic [5:0] sys_next;
    logic [3:0] age_reg;
    logic [3:0] age_next;
    always_comb begin
        sys_next = 6'h00;
        age_next = 4'h0;
        if (nrst && core_reset && sys_clk_run)
            sys_next = (sys_reg == 6'h3f) ? sys_reg : sys_reg + 6'h01;
        if (nrst && reset_pin_n)
            age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    end
    always_ff @(posedge clk) begin
        sys_reg <= sys_next;
        age_reg <= age_next;
    end
    sequence s_fetch;
        vector_fetch ##1 !vector_fetch;
    endsequence
    sequence s_quiet;
        !core_reset [*6];
    endsequence
    a_vector_addr_fixed: assert property (vector_addr == 16'h0002)
        else $error("vector address is not 0002");
    a_fetch_on_exit: assert property ($fell(core_reset) |-> s_fetch)
        else $error("no single fetch pulse on reset exit");
    // a held pin may stretch the phase, but only until just after release
    a_sys_sixteen: assert property ($fell(core_reset) |->
        sys_reg == 6'h10 || (sys_reg > 6'h10 && age_reg < 4'h9))
        else $error("system clock phase is not 16 cycles");
    a_clock_in_run: assert property (!core_reset |-> sys_clk_run)
        else $error("system clock stopped outside reset");
    a_periph_same: assert property (periph_reset == core_reset)
        else $error("peripheral reset differs");
    a_pin_holds: assert property (!reset_pin_n [*8] |-> core_reset)
        else $error("reset pin low but core not in reset");
    a_supply_holds: assert property (
        !supply_good [*8] |-> core_reset && !sys_clk_run)
        else $error("supply bad but core not held");
    a_brown_holds: assert property (
        (brownout_detect && !sleep_mode) [*8] |-> core_reset)
        else $error("brown-out but core not held");
    a_brown_gate: assert property (brownout_enable == !sleep_mode)
        else $error("brown-out detector enable wrong");
    a_port_gate: assert property (
        port_input_enable == (!sleep_mode && !core_reset))
        else $error("port input enable wrong");
    a_capture_pulse: assert property (
        port_input_capture |=> !port_input_capture)
        else $error("capture pulse longer than one cycle");
    a_awake_loads: assert property (
        $rose(core_reset) && !sleep_mode |-> ctrl_reg_load)
        else $error("awake reset without register load");
    a_wdt_option_off: assert property (
        wdt_timeout && !sleep_mode && !core_reset
        && !watchdog_reset_select_option |=> s_quiet)
        else $error("watchdog reset taken with option clear");
endmodule
bind rws_sequencer rws_seq_properties rws_seq_properties_inst (.*);

// >>> testbench/rws_far_model.sv
// Purpose: far side: watchdog oscillator and time-out, core sleep state
// Assumes: bench requests sleep and time-outs by one-cycle pulses
// Notes: core leaves sleep as soon as it is put into reset
`timescale 1ns/1ps
module rws_far_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic core_reset,
    input wire logic sleep_req,
    input wire logic wdt_fire,
    output logic wdt_osc,
    output logic sleep_mode = 1'b0,
    output logic wdt_timeout = 1'b0
);
    logic sleep_next;
    logic tmo_next;
    // free running, phase unrelated to clk; 5.5 clk period keeps runs short
    initial begin
        wdt_osc = 1'b0;
        #7;
        forever #110 wdt_osc = ~wdt_osc;
    end
    always_comb begin
        sleep_next = sleep_mode;
        if (sleep_req)
            sleep_next = 1'b1;
        if (core_reset || !nrst)
            sleep_next = 1'b0;
        tmo_next = wdt_fire && nrst;
    end
    always_ff @(posedge clk) begin
        sleep_mode <= sleep_next;
        wdt_timeout <= tmo_next;
    end
endmodule

// >>> testbench/rws_sequencer_tb.sv
// Purpose: self-checking bench for the reset and wake sequencer
// Assumes: far model gives oscillator, sleep and watchdog pulses
// Notes: src 0 pin, 1 watchdog, 2 debugger, 3 gpio, 4 debug pin,
//        5 brown-out, 6 supply drop, 7 pin then brown-out mid-sequence
`timescale 1ns/1ps
module rws_sequencer_tb;
    logic clk, nrst, supply_good, brownout_detect, wdt_osc, reset_pin_n;
    logic debug_pin, sleep_mode, wdt_timeout, wdt_irq_mode, flag_clear;
    logic watchdog_reset_select_option, debugger_control_reg_bit1;
    logic [rws_pkg::RWS_GPIO_W-1:0] gpio_wake_in, gpio_wake_en;
    logic core_reset, periph_reset, debugger_reset, ctrl_reg_load;
    logic sys_clk_run, brownout_enable, port_input_enable;
    logic port_input_capture, vector_fetch, wdt_irq_request;
    logic por_cause_flag, watchdog_cause_flag, external_pin_cause_flag;
    logic sleep_wake_cause_flag, sleep_req, wdt_fire;
    logic [15:0] vector_addr;
    logic [3:0] flags_m;
    int error_cnt, samples_checked, cyc, oc;
    bit po;
    rws_sequencer rws_sequencer_inst (.*);
    rws_far_model rws_far_model_inst (.*);
    always @(posedge clk) begin
        if (!core_reset || !supply_good || brownout_detect)
            oc <= 0;
        else if (!sys_clk_run && wdt_osc && !po)
            oc <= oc + 1;
        po <= wdt_osc;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(string nm, logic [3:0] e, logic [3:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_cnt(string nm, int lo, int hi, int g);
        samples_checked++;
        if (g < lo || g > hi) begin
            error_cnt++;
            $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask
    function automatic int osc_len(int src, bit slp, logic opt);
        if (src == 6 || src == 7 || src == 2)
            return 514;
        if (slp)
            return (src == 5) ? 0 : 514;
        if (src == 5)
            return 514;
        if (src == 0 || (src == 1 && opt === 1'b1))
            return 66;
        return 0;
    endfunction
    function automatic logic [3:0] next_flags(int src, bit slp,
                                              logic [3:0] f);
        if (src >= 5)
            return rws_pkg::RWS_CAUSE_POR;
        if (slp && src == 1)
            return f | rws_pkg::RWS_CAUSE_WDT_WAKE;
        if (slp && src == 3)
            return f | rws_pkg::RWS_CAUSE_WAKE;
        if (src == 0)
            return rws_pkg::RWS_CAUSE_EXT;
        if (src == 1)
            return rws_pkg::RWS_CAUSE_WDT;
        return rws_pkg::RWS_CAUSE_NONE;
    endfunction
    task automatic trig(int src, int hold);
        int b;
        b = $urandom_range(7);
        reset_pin_n = !(src == 0 || src == 7);
        wdt_fire = (src == 1);
        debugger_control_reg_bit1 = (src == 2);
        debug_pin = (src != 4);
        brownout_detect = (src == 5);
        supply_good = (src != 6);
        if (src == 3) begin
            gpio_wake_en = 8'($urandom()) | (8'h01 << b);
            gpio_wake_in[b] = ~gpio_wake_in[b];
        end
        @(negedge clk);
        wdt_fire = 1'b0;
        repeat (hold) @(negedge clk);
        reset_pin_n = 1'b1;
        if (src == 7) begin
            repeat (100) @(negedge clk);
            brownout_detect = 1'b1;
            repeat (10) @(negedge clk);
        end
        brownout_detect = 1'b0;
        debug_pin = 1'b1;
        supply_good = 1'b1;
        debugger_control_reg_bit1 = 1'b0;
    endtask
    task automatic scen(int src, bit slp, int hold);
        int n, k, sc = 0, age = 0;
        bit hit = 0, cl = 0, dr = 0, cap = 0, irq = 0, w;
        logic [3:0] got;
        w = slp && (src == 1 || src == 3);
        wdt_irq_mode = 1'($urandom_range(1));
        n = osc_len(src, slp, watchdog_reset_select_option);
        if (slp && !sleep_mode) begin
            sleep_req = 1'b1;
            @(negedge clk);
            sleep_req = 1'b0;
            repeat (6) @(negedge clk);
        end
        trig(src, hold);
        for (k = 0; k < 20000; k++) begin
            if (core_reset && sys_clk_run)
                sc++;
            age = reset_pin_n ? age + 1 : 0;
            hit |= core_reset;
            cl |= core_reset & ctrl_reg_load;
            dr |= core_reset & debugger_reset;
            cap |= port_input_capture;
            irq |= wdt_irq_request;
            if (!core_reset && (sc > 0 || (n == 0 && k > 20))) begin
                flag_clear = 1'b0;
                break;
            end
            @(negedge clk);
        end
        chk_cnt("bounded wait", 0, 19999, k);
        if (n == 0) begin
            chk("no reset", 4'h0, 4'(hit));
            if (sleep_mode)
                scen(3, 1'b1, 10);
        end else begin
            flags_m = next_flags(src, slp, flags_m);
            chk("fetch", 4'h1, 4'(vector_fetch));
            if (hold < 100)
                chk_cnt("osc count", n - 2, n + 2, oc);
            if (age > 30)
                chk_cnt("sys count", 16, 16, sc);
            else
                chk_cnt("pin release", 2, 7, age);
            @(negedge clk);
            cap |= port_input_capture;
            irq |= wdt_irq_request;
            got = {sleep_wake_cause_flag, external_pin_cause_flag,
                   watchdog_cause_flag, por_cause_flag};
            chk("load", 4'(!w), 4'(cl));
            chk("debugger reset", 4'(!(w || src == 2)), 4'(dr));
            chk("irq", 4'(w && src == 1 && wdt_irq_mode), 4'(irq));
            chk("capture", 4'(w), 4'(cap));
            chk("flags", flags_m, got);
        end
        $display("test src %0d sleep %0d done", src, slp);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 80000) begin
            error_cnt++;
            $display("MISMATCH run length expected 80000 seen more");
            results();
        end
    end
    initial begin
        int s;
        bit p;
        {nrst, supply_good, brownout_detect, wdt_irq_mode} = 4'h0;
        {flag_clear, sleep_req, wdt_fire, debugger_control_reg_bit1} = 4'h0;
        {reset_pin_n, debug_pin, watchdog_reset_select_option} = 3'h7;
        gpio_wake_in = 8'h00;
        gpio_wake_en = 8'h00;
        flags_m = 4'h0;
        error_cnt = 0;
        samples_checked = 0;
        cyc = 0;
        void'($urandom(32'hab9c0262));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        scen(6, 1'b0, 10);
        for (s = 0; s < 16; s++) begin
            p = s[0];
            if (!(p && ((s >> 1) == 2 || (s >> 1) == 7)))
                scen(s >> 1, p, 10);
        end
        repeat (4) begin
            s = $urandom_range(6);
            p = (s != 2) && ($urandom_range(1) == 1);
            watchdog_reset_select_option = 1'($urandom_range(1));
            scen(s, p, $urandom_range(5, 30));
        end
        watchdog_reset_select_option = 1'b0;
        scen(1, 1'b0, 10);
        flag_clear = 1'b1;
        scen(0, 1'b0, 600);
        flag_clear = 1'b1;
        flags_m = 4'h0;
        scen(3, 1'b1, 10);
        results();
    end
endmodule
